/* File: hdl/logic_cell.sv */
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none

`include "logic_cell_cfg.svh"

module logic_cell
  import logic_cell_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  input wire logic i_ext_input_a,
  input wire logic i_periph_clock,
  input wire logic i_secondary_oscillator,
  input wire logic i_low_power_rc_clock,
  input wire logic i_reference_clock_out,
  input wire logic i_timer2_match,
  input wire logic i_timer3_match,
  input wire logic i_ext_input_b,
  input wire logic i_cell2_output,
  input wire logic i_comparator1,
  input wire logic i_uart1_transmit,
  input wire logic i_adc_done,
  input wire logic i_dma0_irq,
  input wire logic i_capture_compare1_out,
  input wire logic i_capture_compare2_out,
  input wire logic i_ext_input_c,
  input wire logic i_comparator2,
  input wire logic i_spi1_data_out,
  input wire logic i_uart1_receive,
  input wire logic i_dma1_irq,
  input wire logic i_capture_compare3_out,
  input wire logic i_ext_input_d,
  input wire logic i_comparator3,
  input wire logic i_spi1_data_in,
  output logic o_cell_out,
  output logic o_pin_out,
  output logic o_pin_oe,
  output logic o_irq
);

  cell_state_type st_r;
  cell_state_type st_nxt;
  logic [`LC_NSRC-1:0] src_raw;
  logic [`LC_NSRC-1:0] s;
  logic [3:0] d;
  logic [3:0] g_raw;
  logic [3:0] g;
  logic clk_rise;
  logic f;
  logic q_nxt;
  logic out_nxt;
  logic take;

  // order fixes the bit of each source in the synchroniser vector
  assign src_raw = {
    i_spi1_data_in, i_comparator3, i_ext_input_d,
    i_capture_compare3_out, i_dma1_irq, i_uart1_receive,
    i_spi1_data_out, i_comparator2, i_ext_input_c,
    i_capture_compare2_out, i_capture_compare1_out, i_dma0_irq,
    i_adc_done, i_uart1_transmit, i_comparator1, i_cell2_output,
    i_ext_input_b, i_timer3_match, i_timer2_match,
    i_reference_clock_out, i_low_power_rc_clock,
    i_secondary_oscillator, i_periph_clock, i_ext_input_a
  };

  assign s = st_r.sync2;

  // one gate: OR of the enabled true and negated source versions
  function automatic logic gate_or(input logic [7:0] en,
                                   input logic [3:0] src);
    logic acc;
    acc = 1'b0;
    for (int y = 0; y < 4; y++) begin
      acc = acc | (en[2*y+1] & src[y]) | (en[2*y] & ~src[y]);
    end
    return acc;
  endfunction

  // register readback; status bit shows the registered cell output
  function automatic logic [15:0] rd_word(input logic [`LC_IDX_W-1:0] idx,
                                          input cell_state_type r,
                                          input logic stat);
    logic [15:0] w;
    w = `LC_REG_RST;
    if (idx == `LC_IDX_CTL_LO) begin
      w[`LC_EN_BIT] = r.cell_en;
      w[`LC_RISE_BIT] = r.rise_irq_enable;
      w[`LC_FALL_BIT] = r.fall_irq_enable;
      w[`LC_OE_BIT] = r.pin_output_enable;
      w[`LC_STAT_BIT] = stat;
      w[`LC_POL_BIT] = r.output_invert;
      w[2:0] = r.mode;
    end else if (idx == `LC_IDX_CTL_HI) begin
      w[3:0] = r.gate_invert;
    end else if (idx == `LC_IDX_SEL) begin
      w = r.source_select;
    end else if (idx == `LC_IDX_GLS_LO) begin
      w = r.gate_select_low;
    end else if (idx == `LC_IDX_GLS_HI) begin
      w = r.gate_select_high;
    end
    return w;
  endfunction

  // source multiplexers
  always_comb begin
    case (st_r.source_select[2:0]) // [RULE_10]
      3'h0: d[0] = s[0];
      3'h1: d[0] = s[1];
      3'h2: d[0] = s[2];
      3'h3: d[0] = s[3];
      3'h4: d[0] = s[4];
      3'h6: d[0] = s[5];
      3'h7: d[0] = s[6];
      default: d[0] = 1'b0; // [RULE_21]
    endcase
    case (st_r.source_select[`LC_SEL_STRIDE+:3]) // [RULE_11]
      3'h0: d[1] = s[7];
      3'h1: d[1] = s[8];
      3'h2: d[1] = s[9];
      3'h3: d[1] = s[10];
      3'h4: d[1] = s[11];
      3'h5: d[1] = s[12];
      3'h6: d[1] = s[13];
      default: d[1] = s[14];
    endcase
    case (st_r.source_select[2*`LC_SEL_STRIDE+:3]) // [RULE_12]
      3'h0: d[2] = s[15];
      3'h1: d[2] = st_r.cell_out;
      3'h2: d[2] = s[16];
      3'h3: d[2] = s[17];
      3'h4: d[2] = s[18];
      3'h5: d[2] = s[19];
      3'h6: d[2] = s[14];
      default: d[2] = s[20];
    endcase
    case (st_r.source_select[3*`LC_SEL_STRIDE+:3]) // [RULE_13]
      3'h0: d[3] = s[21];
      3'h1: d[3] = s[8];
      3'h2: d[3] = s[22];
      3'h3: d[3] = s[23];
      3'h6: d[3] = s[13];
      3'h7: d[3] = s[20];
      default: d[3] = 1'b0; // [RULE_21]
    endcase
  end

  // input gates and their polarity
  always_comb begin
    g_raw[0] = gate_or(st_r.gate_select_low[7:0], d); // [RULE_15] [RULE_19]
    g_raw[1] = gate_or(st_r.gate_select_low[15:8], d); // [RULE_14]
    g_raw[2] = gate_or(st_r.gate_select_high[7:0], d); // [RULE_16]
    g_raw[3] = gate_or(st_r.gate_select_high[15:8], d);
    g = g_raw ^ st_r.gate_invert; // [RULE_09]
  end

  // logic function; gate 1 is the flip-flop clock, sampled on i_mclk
  always_comb begin
    clk_rise = g[0] & ~st_r.g1_prev; // [RULE_20]
    q_nxt = st_r.q;
    f = 1'b0;
    case (st_r.mode)
      MODE_AND_OR: begin
        f = (g[0] & g[1]) | (g[2] & g[3]); // [RULE_04]
      end
      MODE_OR_XOR: begin
        f = (g[0] | g[1]) ^ (g[2] | g[3]); // [RULE_04]
      end
      MODE_AND4: begin
        f = &g; // [RULE_04]
      end
      MODE_SR: begin
        // set wins when both set and reset are active
        if (g[0] | g[1]) begin
          q_nxt = 1'b1; // [RULE_05]
        end else if (g[2] | g[3]) begin
          q_nxt = 1'b0;
        end
        f = q_nxt;
      end
      MODE_DFF_SR: begin
        if (g[2]) begin
          q_nxt = 1'b0; // [RULE_05]
        end else if (g[3]) begin
          q_nxt = 1'b1;
        end else if (clk_rise) begin
          q_nxt = g[1];
        end
        f = q_nxt;
      end
      MODE_DFF2_R: begin
        if (g[2]) begin
          q_nxt = 1'b0; // [RULE_06]
        end else if (clk_rise) begin
          q_nxt = g[1] & g[3];
        end
        f = q_nxt;
      end
      MODE_JK_R: begin
        if (g[2]) begin
          q_nxt = 1'b0; // [RULE_07]
        end else if (clk_rise) begin
          q_nxt = (g[1] & ~st_r.q) | (~g[3] & st_r.q);
        end
        f = q_nxt;
      end
      default: begin
        if (g[2]) begin
          q_nxt = 1'b0; // [RULE_08]
        end else if (g[3]) begin
          q_nxt = 1'b1;
        end else if (g[0]) begin
          q_nxt = g[1];
        end
        f = q_nxt;
      end
    endcase
    out_nxt = st_r.cell_en & (f ^ st_r.output_invert); // [RULE_03] [RULE_17]
  end

  assign take = i_hsel & i_htrans[1] & i_hready;

  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = src_raw;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.g1_prev = g[0];
    st_nxt.q = st_r.cell_en & q_nxt; // [RULE_17]
    st_nxt.cell_out = out_nxt;
    st_nxt.pin_oe = st_r.pin_output_enable; // [RULE_01]
    st_nxt.pin_out = out_nxt & st_r.pin_output_enable; // [RULE_01]
    st_nxt.irq = (out_nxt & ~st_r.cell_out & st_r.rise_irq_enable) |
                 (~out_nxt & st_r.cell_out & st_r.fall_irq_enable); // [RULE_18]
    // data phase of a write stores i_hwdata at the index taken in the address phase
    if (st_r.wr_pend) begin
      if (st_r.wr_idx == `LC_IDX_CTL_LO) begin
        st_nxt.cell_en = i_hwdata[`LC_EN_BIT];
        st_nxt.rise_irq_enable = i_hwdata[`LC_RISE_BIT];
        st_nxt.fall_irq_enable = i_hwdata[`LC_FALL_BIT];
        st_nxt.pin_output_enable = i_hwdata[`LC_OE_BIT];
        st_nxt.output_invert = i_hwdata[`LC_POL_BIT];
        st_nxt.mode = cell_mode_type'(i_hwdata[2:0]);
      end else if (st_r.wr_idx == `LC_IDX_CTL_HI) begin
        st_nxt.gate_invert = i_hwdata[3:0];
      end else if (st_r.wr_idx == `LC_IDX_SEL) begin
        st_nxt.source_select = i_hwdata[15:0] & `LC_SEL_MASK;
      end else if (st_r.wr_idx == `LC_IDX_GLS_LO) begin
        st_nxt.gate_select_low = i_hwdata[15:0]; // [RULE_15]
      end else if (st_r.wr_idx == `LC_IDX_GLS_HI) begin
        st_nxt.gate_select_high = i_hwdata[15:0]; // [RULE_16]
      end
    end
    st_nxt.wr_pend = take & i_hwrite;
    st_nxt.wr_idx = i_haddr[`LC_IDX_LSB+:`LC_IDX_W];
    // read data is staged from the post-write copy to avoid stale reads
    st_nxt.rdata = 32'h0000_0000;
    if (take & ~i_hwrite) begin
      st_nxt.rdata[15:0] = rd_word(i_haddr[`LC_IDX_LSB+:`LC_IDX_W],
                                   st_nxt, st_r.cell_out); // [RULE_02]
    end
    st_nxt.hready = 1'b1;
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      st_r <= '0;
      st_r.hready <= 1'b1;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  assign o_hreadyout = st_r.hready;
  assign o_hresp = 1'b0;
  assign o_hrdata = st_r.rdata;
  assign o_cell_out = st_r.cell_out;
  assign o_pin_out = st_r.pin_out;
  assign o_pin_oe = st_r.pin_oe;
  assign o_irq = st_r.irq;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);

  a_pin_gated: assert property (!o_pin_oe |-> !o_pin_out) // [RULE_01]
    else $error("pin driven while output enable is clear");

  a_pin_oe_follow: assert property (
    $past(i_ce) && $past(i_ce, 2) |->
      o_pin_oe == $past(st_r.pin_output_enable)) // [RULE_01]
    else $error("pin enable does not follow its control bit");

  a_status_read: assert property (
    $past(i_ce) && $past(take & ~i_hwrite) &&
    $past(i_haddr[`LC_IDX_LSB+:`LC_IDX_W]) == `LC_IDX_CTL_LO |->
      o_hrdata[`LC_STAT_BIT] == $past(o_cell_out)) // [RULE_02]
    else $error("status bit does not show the cell output");

  a_disabled_zero: assert property (
    $past(i_ce) && !$past(st_r.cell_en) |-> !o_cell_out) // [RULE_17]
    else $error("disabled cell drives a one");

  a_andor_mode: assert property (
    $past(i_ce) && $past(st_r.cell_en) &&
    $past(st_r.mode) == MODE_AND_OR |->
      o_cell_out == ($past((g[0] & g[1]) | (g[2] & g[3])) ^
                     $past(st_r.output_invert))) // [RULE_03]
    else $error("and-or result or polarity wrong");

  a_and4_mode: assert property (
    $past(i_ce) && $past(st_r.cell_en) &&
    $past(st_r.mode) == MODE_AND4 |->
      o_cell_out == ($past(&g) ^ $past(st_r.output_invert))) // [RULE_04]
    else $error("four-input and result wrong");

  a_sr_set: assert property (
    $past(i_ce) && $past(st_r.cell_en) && $past(st_r.mode) == MODE_SR &&
    $past(g[0] | g[1]) |->
      o_cell_out == !$past(st_r.output_invert)) // [RULE_05]
    else $error("set-reset latch ignores set");

  a_jk_reset: assert property (
    $past(i_ce) && $past(st_r.cell_en) && $past(st_r.mode) == MODE_JK_R &&
    $past(g[2]) |-> o_cell_out == $past(st_r.output_invert)) // [RULE_07]
    else $error("jk flip-flop ignores reset");

  a_gate_invert: assert property (
    st_r.gate_select_low[7:0] == 8'h00 |->
      g[0] == st_r.gate_invert[0]) // [RULE_09]
    else $error("empty gate does not follow its invert control");

  a_unimpl_zero: assert property (
    st_r.source_select[2:0] == 3'h5 |-> d[0] == 1'b0) // [RULE_21]
    else $error("unimplemented source code is not zero");

  a_rise_irq: assert property (
    $past(i_ce) && $rose(o_cell_out) && $past(st_r.rise_irq_enable)
      |-> o_irq) // [RULE_18]
    else $error("rising edge did not raise the interrupt");

  a_irq_quiet: assert property (
    $past(i_ce) && $stable(o_cell_out) |-> !o_irq) // [RULE_18]
    else $error("interrupt without an output edge");

  a_orxor_mode: assert property (
    $past(i_ce) && $past(st_r.cell_en) &&
    $past(st_r.mode) == MODE_OR_XOR |->
      o_cell_out == ($past((g[0] | g[1]) ^ (g[2] | g[3])) ^
                     $past(st_r.output_invert))) // [RULE_04]
    else $error("or-xor result or polarity wrong");

  a_dff2_reset: assert property (
    $past(i_ce) && $past(st_r.cell_en) && $past(st_r.mode) == MODE_DFF2_R &&
    $past(g[2]) |-> o_cell_out == $past(st_r.output_invert)) // [RULE_06]
    else $error("two-input flip-flop ignores reset");

  a_latch_reset: assert property (
    $past(i_ce) && $past(st_r.cell_en) && $past(st_r.mode) == MODE_LATCH_SR &&
    $past(g[2]) |-> o_cell_out == $past(st_r.output_invert)) // [RULE_08]
    else $error("transparent latch ignores reset");

  a_fall_irq: assert property (
    $past(i_ce) && $fell(o_cell_out) && $past(st_r.fall_irq_enable)
      |-> o_irq) // [RULE_18]
    else $error("falling edge did not raise the interrupt");

  c_read_ctl: cover property (
    take && !i_hwrite &&
    i_haddr[`LC_IDX_LSB+:`LC_IDX_W] == `LC_IDX_CTL_LO);
  c_jk_toggle: cover property (
    st_r.mode == MODE_JK_R && st_r.cell_en && clk_rise ##1 $changed(st_r.q));
  c_fall_irq: cover property ($fell(o_cell_out) && o_irq);
  c_pin_drive: cover property (o_pin_oe && o_pin_out);

endmodule

`default_nettype wire

/* File: include/logic_cell_cfg.svh */
// Behaviour
// RULE_01: pin output enable set drives cell result to pin; clear disables it.
// RULE_02: read-only status bit reads 1 while cell output high, else 0.
// RULE_03: output invert control 1 inverts final output; 0 passes it unchanged.
// RULE_04: mode 000 AND-OR, 001 OR-XOR, 010 four-input AND of gates.
// RULE_05: mode 011 set-reset latch; 100 one-input D flip-flop with set, reset.
// RULE_06: mode 101 D flip-flop with two data inputs combined and reset.
// RULE_07: mode 110 JK flip-flop with reset input.
// RULE_08: mode 111 one-input transparent latch with set and reset.
// RULE_09: per-gate invert control 1 inverts that gate before the function.
// RULE_10: source mux 1 codes: pin A, clocks, reference clock, timers; 101 empty.
// RULE_11: source mux 2 codes: pin B, cell 2, comparator, uart, converter, dma.
// RULE_12: source mux 3 codes: pin C, own output, comparator, spi, uart, dma.
// RULE_13: source mux 4 codes: pin D, cell 2, comparator, spi; 100,101 empty.
// RULE_14: each gate has true and negated enable for every mux output.
// RULE_15: low gate select holds gate 1 in bits 7:0, gate 2 in 15:8.
// RULE_16: high gate select holds gate 3 in bits 7:0, gate 4 in 15:8.
// RULE_17: cell enable set combines inputs; clear holds outputs at zero.
// RULE_18: rise and fall enables raise an interrupt on matching output edges.
// RULE_19: each gate ORs all enabled true and negated mux outputs.
// RULE_20: gates pair as 1&2 and 3&4; gate 1 clocks flip-flops.
// RULE_21: an unimplemented mux code yields constant zero.
`ifndef LOGIC_CELL_CFG_SVH
`define LOGIC_CELL_CFG_SVH

`define LC_IDX_W 11
`define LC_IDX_LSB 2
`define LC_IDX_CTL_LO 11'h464
`define LC_IDX_CTL_HI 11'h466
`define LC_IDX_SEL 11'h468
`define LC_IDX_GLS_LO 11'h46c
`define LC_IDX_GLS_HI 11'h46e

`define LC_REG_RST 16'h0000
`define LC_SEL_MASK 16'h7777
`define LC_INV_MASK 16'h000f

`define LC_EN_BIT 15
`define LC_RISE_BIT 11
`define LC_FALL_BIT 10
`define LC_OE_BIT 7
`define LC_STAT_BIT 6
`define LC_POL_BIT 5
`define LC_SEL_STRIDE 4

`define LC_MODE_AND_OR 3'b000
`define LC_MODE_OR_XOR 3'b001
`define LC_MODE_AND4 3'b010
`define LC_MODE_SR 3'b011
`define LC_MODE_DFF_SR 3'b100
`define LC_MODE_DFF2_R 3'b101
`define LC_MODE_JK_R 3'b110
`define LC_MODE_LATCH_SR 3'b111

`define LC_NSRC 24

`endif

/* File: include/logic_cell_pkg.sv */
`include "logic_cell_cfg.svh"

package logic_cell_pkg;

  typedef enum logic [2:0] {
    MODE_AND_OR = `LC_MODE_AND_OR,
    MODE_OR_XOR = `LC_MODE_OR_XOR,
    MODE_AND4 = `LC_MODE_AND4,
    MODE_SR = `LC_MODE_SR,
    MODE_DFF_SR = `LC_MODE_DFF_SR,
    MODE_DFF2_R = `LC_MODE_DFF2_R,
    MODE_JK_R = `LC_MODE_JK_R,
    MODE_LATCH_SR = `LC_MODE_LATCH_SR
  } cell_mode_type;

  typedef struct packed {
    logic [`LC_NSRC-1:0] sync1;
    logic [`LC_NSRC-1:0] sync2;
    logic cell_en;
    logic rise_irq_enable;
    logic fall_irq_enable;
    logic pin_output_enable;
    logic output_invert;
    cell_mode_type mode;
    logic [3:0] gate_invert;
    logic [15:0] source_select;
    logic [15:0] gate_select_low;
    logic [15:0] gate_select_high;
    logic q;
    logic g1_prev;
    logic cell_out;
    logic pin_out;
    logic pin_oe;
    logic irq;
    logic wr_pend;
    logic [`LC_IDX_W-1:0] wr_idx;
    logic [31:0] rdata;
    logic hready;
  } cell_state_type;

endpackage

/* File: bench/source_model.sv */
`timescale 1ns/10ps
`default_nettype none

module source_model (
  input wire logic i_mclk,
  input wire logic [23:0] i_levels,
  output logic [23:0] o_src
);
  // peripheral and pin levels move just after a clock edge
  always @(posedge i_mclk) begin
    o_src <= i_levels;
  end
endmodule

`default_nettype wire

/* File: bench/configurable_logic_cell_bench.sv */
`timescale 1ns/10ps
`default_nettype none

module configurable_logic_cell_bench;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [23:0] levels = 24'h0;
  wire logic [23:0] src;
  wire logic hreadyout;
  wire logic hresp;
  wire logic [31:0] hrdata;
  wire logic cell_out;
  wire logic pin_out;
  wire logic pin_oe;
  wire logic irq;
  int bad_count = 0;
  int num_checks = 0;
  int irq_seen;
  logic [31:0] d;
  // source bit per mux code; -1 unimplemented, -2 own output
  int src_of[32] = '{0, 1, 2, 3, 4, -1, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14,
    15, -2, 16, 17, 18, 19, 14, 20, 21, 8, 22, 23, -1, -1, 13, 20};
  // {mode, expected output, gates 4..1}
  logic [7:0] seq[38] = '{8'h60, 8'h71, 8'h70, 8'h64, 8'h60, 8'h75,
    8'h80, 8'h82, 8'h93, 8'h91, 8'h90, 8'h81, 8'h98, 8'h8c,
    8'ha0, 8'haa, 8'hbb, 8'hb2, 8'ha3, 8'haa, 8'hbb, 8'haf,
    8'hc0, 8'hc2, 8'hd3, 8'hda, 8'hcb, 8'hca, 8'hdb, 8'hc6,
    8'he0, 8'hf3, 8'he1, 8'hf3, 8'hf2, 8'hf0, 8'he4, 8'hf8};
  logic [10:0] ra[6] = '{11'h464, 11'h466, 11'h468, 11'h46c, 11'h46e,
    11'h465};
  logic [15:0] rx[6] = '{16'h0ca7, 16'h000f, 16'h7777, 16'hffff,
    16'hffff, 16'h0000};

  always #20 mclk = ~mclk;

  logic_cell logic_cell_inst (
    .i_mclk(mclk), .i_sys_rst(sys_rst), .i_ce(ce), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hreadyout),
    .o_hreadyout(hreadyout), .o_hresp(hresp), .o_hrdata(hrdata),
    .i_ext_input_a(src[0]), .i_periph_clock(src[1]),
    .i_secondary_oscillator(src[2]), .i_low_power_rc_clock(src[3]),
    .i_reference_clock_out(src[4]), .i_timer2_match(src[5]),
    .i_timer3_match(src[6]), .i_ext_input_b(src[7]),
    .i_cell2_output(src[8]), .i_comparator1(src[9]),
    .i_uart1_transmit(src[10]), .i_adc_done(src[11]),
    .i_dma0_irq(src[12]), .i_capture_compare1_out(src[13]),
    .i_capture_compare2_out(src[14]), .i_ext_input_c(src[15]),
    .i_comparator2(src[16]), .i_spi1_data_out(src[17]),
    .i_uart1_receive(src[18]), .i_dma1_irq(src[19]),
    .i_capture_compare3_out(src[20]), .i_ext_input_d(src[21]),
    .i_comparator3(src[22]), .i_spi1_data_in(src[23]),
    .o_cell_out(cell_out), .o_pin_out(pin_out), .o_pin_oe(pin_oe),
    .o_irq(irq)
  );

  source_model source_model_inst (
    .i_mclk(mclk), .i_levels(levels), .o_src(src)
  );

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [10:0] idx,
                     input logic [15:0] wd);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {19'h0, idx, 2'h0};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {16'h0, wd};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask

  // sources land at the cell output four edges after they are driven
  task automatic step(input logic [23:0] lv);
    @(posedge mclk);
    levels <= lv;
    irq_seen = 0;
    repeat (5) begin
      @(posedge mclk);
      if (irq === 1'b1) irq_seen++;
    end
  endtask

  function automatic logic [23:0] glv(input logic [3:0] g);
    glv = {2'h0, g[3], 5'h0, g[2], 7'h0, g[1], 6'h0, g[0]};
  endfunction

  function automatic logic fn(input int m, input logic [3:0] g);
    if (m == 0) fn = (g[0] & g[1]) | (g[2] & g[3]);
    else if (m == 1) fn = (g[0] | g[1]) ^ (g[2] | g[3]);
    else fn = &g;
  endfunction

  initial begin
    int i;
    int pm;
    logic [31:0] cw;
    logic e;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int r = 0; r < 6; r++) begin
      bus(1'b0, ra[r], 16'h0);
      chk(d, 32'h0);
      bus(1'b1, ra[r], (r == 0) ? 16'h7fff : 16'hffff);
      bus(1'b0, ra[r], 16'h0);
      chk(d, {16'h0, rx[r]});
      chk({30'h0, hreadyout, hresp}, 32'h2);
    end
    $display("register test done");
    bus(1'b1, 11'h468, 16'h0000);
    bus(1'b1, 11'h46c, 16'h0802);
    bus(1'b1, 11'h46e, 16'h8020);
    for (int m = 0; m < 3; m++) begin
      for (int p = 0; p < 2; p++) begin
        bus(1'b1, 11'h466, p ? 16'h0005 : 16'h0000);
        cw = 32'h8000 | (p << 7) | (p << 5) | m;
        bus(1'b1, 11'h464, cw[15:0]);
        for (int g = 0; g < 16; g++) begin
          step(glv(4'(g)));
          e = fn(m, 4'(g) ^ (p ? 4'h5 : 4'h0)) ^ p[0];
          chk({31'h0, cell_out}, {31'h0, e});
          chk({30'h0, pin_oe, pin_out}, {30'h0, p[0], e & p[0]});
          bus(1'b0, 11'h464, 16'h0);
          chk(d, cw | (e << 6));
        end
      end
    end
    $display("combinational test done");
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, 11'h464, k ? 16'h0022 : 16'h0002);
      step(glv(4'hf));
      chk({30'h0, cell_out, pin_out}, 32'h0);
    end
    $display("disable test done");
    step(24'h0);
    bus(1'b1, 11'h46c, 16'h0002);
    bus(1'b1, 11'h46e, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, 11'h464, (k < 2) ? 16'h8801 : 16'h8401);
      step({23'h0, ~k[0]});
      chk(irq_seen, (k == 0 || k == 3) ? 1 : 0);
    end
    $display("interrupt test done");
    bus(1'b1, 11'h464, 16'h8001);
    for (int m = 0; m < 4; m++) begin
      for (int c = 0; c < 8; c++) begin
        i = src_of[m * 8 + c];
        if (i == -2) continue;
        bus(1'b1, 11'h468, 16'(c << (4 * m)));
        bus(1'b1, 11'h46c, 16'(1 << (2 * m + 1)));
        step((i < 0) ? 24'hffffff : ~(24'h1 << i));
        chk({31'h0, cell_out}, 32'h0);
        if (i >= 0) begin
          step(24'h1 << i);
          chk({31'h0, cell_out}, 32'h1);
        end
      end
    end
    // own output fed back negated makes the cell toggle every clock
    bus(1'b1, 11'h468, 16'h0100);
    bus(1'b1, 11'h46c, 16'h0010);
    @(posedge mclk);
    e = cell_out;
    @(posedge mclk);
    chk({31'h0, cell_out}, {31'h0, ~e});
    bus(1'b1, 11'h468, 16'h0000);
    bus(1'b1, 11'h46c, 16'h0009);
    step(24'h000001);
    chk({31'h0, cell_out}, 32'h0);
    step(24'h000081);
    chk({31'h0, cell_out}, 32'h1);
    // a low clock enable holds the output through a source change
    ce <= 1'b0;
    step(24'h000001);
    chk({31'h0, cell_out}, 32'h1);
    ce <= 1'b1;
    step(24'h000001);
    chk({31'h0, cell_out}, 32'h0);
    $display("source test done");
    bus(1'b1, 11'h46c, 16'h0802);
    bus(1'b1, 11'h466, 16'h0000);
    bus(1'b1, 11'h46e, 16'h8020);
    pm = -1;
    for (int j = 0; j < 38; j++) begin
      if (int'(seq[j][7:5]) != pm) begin
        step(24'h0);
        bus(1'b1, 11'h464, 16'h0000);
        bus(1'b1, 11'h464, {13'h1000, seq[j][7:5]});
        pm = int'(seq[j][7:5]);
      end
      step(glv(seq[j][3:0]));
      chk({31'h0, cell_out}, {31'h0, seq[j][4]});
    end
    $display("sequential test done");
    print_verdict;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    print_verdict;
  end
endmodule

`default_nettype wire
